// >>> hdl/user_break_match_unit.sv
`timescale 1ns/1ns
module user_break_match_unit (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     srst,
  // Observed bus cycle with its exceptions
  input  wire break_pkg::bus_cycle_t    cyc,
  // Setting access from the memory access stage
  input  wire break_pkg::cfg_access_t   acc,
  output logic [31:0]                   rd_data,
  // Exception arbitration result
  output logic                          break_req,
  output logic                          break_after,
  output break_pkg::take_t              take,
  // Sticky channel flags
  output logic                          flag_a,
  output logic                          flag_b
);

  // ==========================================================
  // Settings
  logic [31:0] a_addr, a_mask, b_addr, b_mask, b_data, b_dmask, ctl;
  logic [7:0]  a_sel, a_asid, b_sel, b_asid;
  logic [15:0] count_target;
  logic [31:0] next_a_addr, next_a_mask, next_b_addr, next_b_mask;
  logic [31:0] next_b_data, next_b_dmask, next_ctl, next_rd_data;
  logic [7:0]  next_a_sel, next_a_asid, next_b_sel, next_b_asid;
  logic [15:0] next_count_target;
  // Match state
  logic        armed, next_armed;
  logic [15:0] count, next_count;
  logic        next_break_req, next_break_after;
  break_pkg::take_t next_take;
  logic        hit_a, hit_b, fire_a, fire_b, b_qual, a_fetch_before, seq, cnt_en;
  logic        wr_ok, rd_ok;
  break_pkg::chan_cfg_t cfg_a, cfg_b;

  // Channel setting bundles
  assign cfg_a = '{addr: a_addr, mask: a_mask, sel: a_sel, asid: a_asid,
                   asid_en: !ctl[break_pkg::CTL_NOASID_A], data: 32'h00000000,
                   dmask: 32'h00000000, data_en: 1'b0};
  assign cfg_b = '{addr: b_addr, mask: b_mask, sel: b_sel, asid: b_asid,
                   asid_en: !ctl[break_pkg::CTL_NOASID_B], data: b_data,
                   dmask: b_dmask, data_en: ctl[break_pkg::CTL_DATA_EN]};

  // ==========================================================
  // Comparators
  chan_match u_chan_a (
    .cfg (cfg_a),
    .cyc (cyc),
    .hit (hit_a)
  );

  chan_match u_chan_b (
    .cfg (cfg_b),
    .cyc (cyc),
    .hit (hit_b)
  );

  // Mode decode
  assign seq    = ctl[break_pkg::CTL_SEQ];
  assign cnt_en = ctl[break_pkg::CTL_CNT_EN];
  assign a_fetch_before = !ctl[break_pkg::CTL_A_AFTER] &&
    break_pkg::sel_field(a_sel, break_pkg::SEL_TYPE_LSB) == break_pkg::TYPE_FETCH;
  assign wr_ok = acc.req && acc.write && !acc.from_dma;
  assign rd_ok = acc.req && !acc.write && !acc.from_dma;

  // ==========================================================
  // Settings next values; written values land at the end of this cycle
  always_comb
  begin
    next_a_addr       = a_addr;
    next_a_mask       = a_mask;
    next_a_sel        = a_sel;
    next_a_asid       = a_asid;
    next_b_addr       = b_addr;
    next_b_mask       = b_mask;
    next_b_sel        = b_sel;
    next_b_asid       = b_asid;
    next_b_data       = b_data;
    next_b_dmask      = b_dmask;
    next_ctl          = ctl;
    next_count_target = count_target;
    if (wr_ok)
    begin
      unique case (acc.index)
        break_pkg::IDX_A_ADDR:  next_a_addr       = acc.wdata;
        break_pkg::IDX_A_MASK:  next_a_mask       = acc.wdata;
        break_pkg::IDX_A_SEL:   next_a_sel        = acc.wdata[7:0];
        break_pkg::IDX_A_ASID:  next_a_asid       = acc.wdata[7:0];
        break_pkg::IDX_B_ADDR:  next_b_addr       = acc.wdata;
        break_pkg::IDX_B_MASK:  next_b_mask       = acc.wdata;
        break_pkg::IDX_B_SEL:   next_b_sel        = acc.wdata[7:0];
        break_pkg::IDX_B_ASID:  next_b_asid       = acc.wdata[7:0];
        break_pkg::IDX_B_DATA:  next_b_data       = acc.wdata;
        break_pkg::IDX_B_DMASK: next_b_dmask      = acc.wdata;
        break_pkg::IDX_CTL:     next_ctl          = acc.wdata;
        break_pkg::IDX_COUNT:   next_count_target = acc.wdata[15:0];
        default:                next_ctl          = ctl;
      endcase
    end
    // Flag set wins over a clearing write
    if (hit_a)
      next_ctl[break_pkg::CTL_FLAG_A] = 1'b1;
    if (fire_b)
      next_ctl[break_pkg::CTL_FLAG_B] = 1'b1;
    next_rd_data = 32'h00000000;
    if (rd_ok)
    begin
      unique case (acc.index)
        break_pkg::IDX_A_ADDR:  next_rd_data = a_addr;
        break_pkg::IDX_A_MASK:  next_rd_data = a_mask;
        break_pkg::IDX_A_SEL:   next_rd_data = {24'h000000, a_sel};
        break_pkg::IDX_A_ASID:  next_rd_data = {24'h000000, a_asid};
        break_pkg::IDX_B_ADDR:  next_rd_data = b_addr;
        break_pkg::IDX_B_MASK:  next_rd_data = b_mask;
        break_pkg::IDX_B_SEL:   next_rd_data = {24'h000000, b_sel};
        break_pkg::IDX_B_ASID:  next_rd_data = {24'h000000, b_asid};
        break_pkg::IDX_B_DATA:  next_rd_data = b_data;
        break_pkg::IDX_B_DMASK: next_rd_data = b_dmask;
        break_pkg::IDX_CTL:     next_rd_data = ctl;
        break_pkg::IDX_COUNT:   next_rd_data = {16'h0000, count_target};
        default:                next_rd_data = 32'h00000000;
      endcase
    end
  end

  // Settings registers
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      a_addr       <= break_pkg::RST_WORD;
      a_mask       <= break_pkg::RST_WORD;
      a_sel        <= 8'h00;
      a_asid       <= 8'h00;
      b_addr       <= break_pkg::RST_WORD;
      b_mask       <= break_pkg::RST_WORD;
      b_sel        <= 8'h00;
      b_asid       <= 8'h00;
      b_data       <= break_pkg::RST_WORD;
      b_dmask      <= break_pkg::RST_WORD;
      ctl          <= break_pkg::RST_WORD;
      count_target <= break_pkg::RST_COUNT;
      rd_data      <= break_pkg::RST_WORD;
    end
    else
    begin
      a_addr       <= next_a_addr;
      a_mask       <= next_a_mask;
      a_sel        <= next_a_sel;
      a_asid       <= next_a_asid;
      b_addr       <= next_b_addr;
      b_mask       <= next_b_mask;
      b_sel        <= next_b_sel;
      b_asid       <= next_b_asid;
      b_data       <= next_b_data;
      b_dmask      <= next_b_dmask;
      ctl          <= next_ctl;
      count_target <= next_count_target;
      rd_data      <= next_rd_data;
    end
  end

  // Flag outputs straight from the control register
  assign flag_a = ctl[break_pkg::CTL_FLAG_A];
  assign flag_b = ctl[break_pkg::CTL_FLAG_B];

  // ==========================================================
  // Sequence, count and arbitration
  always_comb
  begin
    // Channel B qualifies alone, or after an earlier A in sequence mode
    if (!seq)
      b_qual = hit_b;
    else
      b_qual = hit_b && (armed || (hit_a && a_fetch_before));
    next_armed = armed;
    if (!seq)
      next_armed = 1'b0;
    else if (b_qual)
      next_armed = 1'b0;
    else if (hit_a && !hit_b)
      next_armed = 1'b1;
    next_count = count;
    fire_b     = b_qual;
    if (wr_ok && acc.index == break_pkg::IDX_COUNT)
      next_count = acc.wdata[15:0];
    else if (cnt_en && b_qual)
    begin
      if (count <= 16'h0001)
        next_count = count_target;
      else
      begin
        next_count = count - 16'h0001;
        fire_b     = 1'b0;
      end
    end
    fire_a           = !seq && hit_a;
    next_break_after = (fire_a && ctl[break_pkg::CTL_A_AFTER]) ||
                       (fire_b && ctl[break_pkg::CTL_B_AFTER]);
    // Fetch fault wins, then before-execution break; after-execution yields to operand faults
    if (cyc.valid && cyc.fetch_exc)
      next_take = break_pkg::TAKE_FETCH;
    else if ((fire_a && !ctl[break_pkg::CTL_A_AFTER]) ||
             (fire_b && !ctl[break_pkg::CTL_B_AFTER]))
      next_take = break_pkg::TAKE_BREAK;
    else if (cyc.valid && cyc.operand_exc)
      next_take = break_pkg::TAKE_OPERAND;
    else if (fire_a || fire_b)
      next_take = break_pkg::TAKE_BREAK;
    else
      next_take = break_pkg::TAKE_NONE;
    next_break_req = next_take == break_pkg::TAKE_BREAK;
    if (!next_break_req)
      next_break_after = 1'b0;
  end

  // Match state registers
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      armed       <= 1'b0;
      count       <= break_pkg::RST_COUNT;
      break_req   <= 1'b0;
      break_after <= 1'b0;
      take        <= break_pkg::TAKE_NONE;
    end
    else
    begin
      armed       <= next_armed;
      count       <= next_count;
      break_req   <= next_break_req;
      break_after <= next_break_after;
      take        <= next_take;
    end
  end

  // ==========================================================
  // Checks
  a_fetch_write_none: assert property (@(posedge sys_clk) disable iff (srst)
    (break_pkg::sel_field(a_sel, break_pkg::SEL_TYPE_LSB) == break_pkg::TYPE_FETCH &&
     break_pkg::sel_field(a_sel, break_pkg::SEL_DIR_LSB) == break_pkg::DIR_WRITE) |-> !hit_a)
    else $error("fetch-write channel matched");

  a_odd_fetch_none: assert property (@(posedge sys_clk) disable iff (srst)
    (cyc.fetch && b_addr[0] && !b_mask[0]) |-> !hit_b)
    else $error("odd fetch address matched");

  a_dma_fetch_none: assert property (@(posedge sys_clk) disable iff (srst)
    (break_pkg::sel_field(b_sel, break_pkg::SEL_SRC_LSB) == break_pkg::SRC_DMA &&
     break_pkg::sel_field(b_sel, break_pkg::SEL_TYPE_LSB) == break_pkg::TYPE_FETCH) |-> !hit_b)
    else $error("DMA fetch channel matched");

  a_mask_honoured: assert property (@(posedge sys_clk) disable iff (srst)
    hit_a |-> ((cyc.addr[31:2] ^ a_addr[31:2]) & ~a_mask[31:2]) == 30'h00000000)
    else $error("unmasked address bits differ on a match");

  a_indep_break: assert property (@(posedge sys_clk) disable iff (srst)
    (!seq && hit_a && !ctl[break_pkg::CTL_A_AFTER] && !cyc.fetch_exc) |=> break_req && flag_a)
    else $error("independent channel A match gave no break");

  a_seq_order: assert property (@(posedge sys_clk) disable iff (srst)
    (seq && !armed && !(hit_a && a_fetch_before) && !cyc.operand_exc) |=> !break_req)
    else $error("sequence break without earlier channel A");

  a_count_skip: assert property (@(posedge sys_clk) disable iff (srst)
    (cnt_en && b_qual && count > 16'h0001 && !wr_ok) |=> count == $past(count) - 16'h0001)
    else $error("execution count did not step");

  a_dma_no_write: assert property (@(posedge sys_clk) disable iff (srst)
    (acc.req && acc.from_dma) |=> $stable(a_addr) && $stable(b_data) && rd_data == 32'h0)
    else $error("DMA access reached the settings");

  a_fetch_exc_first: assert property (@(posedge sys_clk) disable iff (srst)
    (cyc.valid && cyc.fetch_exc) |=> !break_req && take == break_pkg::TAKE_FETCH)
    else $error("break taken over fetch exception");

  a_after_yields: assert property (@(posedge sys_clk) disable iff (srst)
    (!seq && hit_a && ctl[break_pkg::CTL_A_AFTER] && !hit_b && cyc.operand_exc &&
     !cyc.fetch_exc) |=> take == break_pkg::TAKE_OPERAND)
    else $error("after-execution break beat operand exception");

endmodule : user_break_match_unit

// >>> hdl/break_pkg.sv
package break_pkg;

  // ==========================================================
  // Cycle select fields, two bits each, code 0 means any, except the source field, where code 0 never matches
  localparam int       SEL_SRC_LSB   = 6;
  localparam int       SEL_TYPE_LSB  = 4;
  localparam int       SEL_DIR_LSB   = 2;
  localparam int       SEL_SIZE_LSB  = 0;
  localparam logic [1:0] SRC_CPU     = 2'h1;
  localparam logic [1:0] SRC_DMA     = 2'h2;
  localparam logic [1:0] TYPE_FETCH  = 2'h1;
  localparam logic [1:0] TYPE_DATA   = 2'h2;
  localparam logic [1:0] DIR_READ    = 2'h1;
  localparam logic [1:0] DIR_WRITE   = 2'h2;
  localparam logic [1:0] SIZE_ANY    = 2'h0;
  localparam logic [1:0] SIZE_BYTE   = 2'h1;
  localparam logic [1:0] SIZE_WORD   = 2'h2;
  localparam logic [1:0] SIZE_LONG   = 2'h3;

  // ==========================================================
  // Break control bit positions
  localparam int CTL_CNT_EN   = 0;
  localparam int CTL_SEQ      = 3;
  localparam int CTL_B_AFTER  = 6;
  localparam int CTL_DATA_EN  = 7;
  localparam int CTL_A_AFTER  = 10;
  localparam int CTL_FLAG_B   = 14;
  localparam int CTL_FLAG_A   = 15;
  localparam int CTL_NOASID_B = 20;
  localparam int CTL_NOASID_A = 21;

  // ==========================================================
  // Setting indices and reset values
  localparam logic [3:0] IDX_A_ADDR  = 4'h0;
  localparam logic [3:0] IDX_A_MASK  = 4'h1;
  localparam logic [3:0] IDX_A_SEL   = 4'h2;
  localparam logic [3:0] IDX_A_ASID  = 4'h3;
  localparam logic [3:0] IDX_B_ADDR  = 4'h4;
  localparam logic [3:0] IDX_B_MASK  = 4'h5;
  localparam logic [3:0] IDX_B_SEL   = 4'h6;
  localparam logic [3:0] IDX_B_ASID  = 4'h7;
  localparam logic [3:0] IDX_B_DATA  = 4'h8;
  localparam logic [3:0] IDX_B_DMASK = 4'h9;
  localparam logic [3:0] IDX_CTL     = 4'hA;
  localparam logic [3:0] IDX_COUNT   = 4'hB;
  localparam logic [31:0] RST_WORD   = 32'h00000000;
  localparam logic [15:0] RST_COUNT  = 16'h0000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic        dma;
    logic        fetch;
    logic        write;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] data;
    logic [7:0]  asid;
    logic        fetch_exc;
    logic        operand_exc;
  } bus_cycle_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] mask;
    logic [7:0]  sel;
    logic [7:0]  asid;
    logic        asid_en;
    logic [31:0] data;
    logic [31:0] dmask;
    logic        data_en;
  } chan_cfg_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        from_dma;
    logic [3:0]  index;
    logic [31:0] wdata;
  } cfg_access_t;

  typedef enum logic [1:0] {TAKE_NONE, TAKE_BREAK, TAKE_FETCH, TAKE_OPERAND} take_t;

  // Two-bit field of a cycle select value
  function automatic logic [1:0] sel_field(input logic [7:0] sel, input int lsb);
    return sel[lsb +: 2];
  endfunction : sel_field

endpackage : break_pkg

// >>> hdl/chan_match.sv
`timescale 1ns/1ns
module chan_match (
  // Channel settings and observed cycle
  input  wire break_pkg::chan_cfg_t  cfg,
  input  wire break_pkg::bus_cycle_t cyc,
  // Combinational match
  output logic                       hit
);

  // ==========================================================
  // Comparator
  always_comb
  begin
    logic [1:0]  src;
    logic [1:0]  typ;
    logic [1:0]  dir;
    logic [1:0]  sz;
    logic [31:0] care;
    logic [31:0] dcare;
    logic        src_ok;
    dcare  = 32'h00000000;
    src_ok = 1'b0;
    src   = break_pkg::sel_field(cfg.sel, break_pkg::SEL_SRC_LSB);
    typ   = break_pkg::sel_field(cfg.sel, break_pkg::SEL_TYPE_LSB);
    dir   = break_pkg::sel_field(cfg.sel, break_pkg::SEL_DIR_LSB);
    sz    = break_pkg::sel_field(cfg.sel, break_pkg::SEL_SIZE_LSB);
    care  = ~cfg.mask;
    // Fetches compare bit 0 so an odd target never hits
    if (!cyc.fetch && cyc.size == break_pkg::SIZE_LONG)
      care[1:0] = 2'h0;
    else if (!cyc.fetch && cyc.size == break_pkg::SIZE_WORD)
      care[0] = 1'b0;
    if (cyc.size == break_pkg::SIZE_LONG)
      dcare = 32'hFFFFFFFF;
    else if (cyc.size == break_pkg::SIZE_WORD)
      dcare = 32'h0000FFFF;
    else
      dcare = 32'h000000FF;
    dcare  = dcare & ~cfg.dmask;
    src_ok = (src == break_pkg::SRC_CPU && !cyc.dma) ||
             (src == break_pkg::SRC_DMA && cyc.dma);
    hit = cyc.valid && src_ok &&
          !(typ == break_pkg::TYPE_FETCH && dir == break_pkg::DIR_WRITE) &&
          !(src == break_pkg::SRC_DMA && typ == break_pkg::TYPE_FETCH) &&
          (typ == 2'h0 || (typ == break_pkg::TYPE_FETCH) == cyc.fetch) &&
          (dir == 2'h0 || (dir == break_pkg::DIR_WRITE) == cyc.write) &&
          (sz == break_pkg::SIZE_ANY || sz == cyc.size) &&
          (((cyc.addr ^ cfg.addr) & care) == 32'h00000000) &&
          (!cfg.asid_en || cyc.asid == cfg.asid) &&
          (!cfg.data_en || cyc.fetch ||
           ((cyc.data ^ cfg.data) & dcare) == 32'h00000000);
  end

endmodule : chan_match

// >>> verification/core_pipe_model.sv
`timescale 1ns/1ns
// ==========================================================
// Core pipeline side: presents bus cycles and setting accesses
module core_pipe_model (
  // Toward the match unit
  output break_pkg::bus_cycle_t  cyc,
  output break_pkg::cfg_access_t acc
);
  break_pkg::bus_cycle_t  last_cyc;
  break_pkg::cfg_access_t last_acc;

  // Quiet start before the first request
  initial
  begin
    last_cyc = '0;
    last_acc = '0;
    cyc      = '0;
    acc      = '0;
  end

  // Idle fields show the inverse of the last ones, so nothing stale can match
  task automatic drive(input break_pkg::bus_cycle_t c, input break_pkg::cfg_access_t a);
    break_pkg::bus_cycle_t  tc;
    break_pkg::cfg_access_t ta;
    tc       = c.valid ? c : ~last_cyc;
    tc.valid = c.valid;
    ta       = a.req ? a : ~last_acc;
    ta.req   = a.req;
    last_cyc = tc;
    last_acc = ta;
    cyc      = tc;
    acc      = ta;
  endtask : drive
endmodule : core_pipe_model

// >>> verification/user_break_match_unit_tb.sv
`timescale 1ns/1ns
// ==========================================================
// Bench with a reference model checked every cycle outside reset
module user_break_match_unit_tb;
  logic                   sys_clk;
  logic                   srst = 1'b1;
  break_pkg::bus_cycle_t  cyc;
  break_pkg::cfg_access_t acc;
  logic [31:0]            rd_data;
  logic                   break_req;
  logic                   break_after;
  break_pkg::take_t       take;
  logic                   flag_a;
  logic                   flag_b;
  int                     n_errors = 0;
  int                     n_tests = 0;
  int                     n_cycles = 0;
  logic [31:0]            cfg [12];
  logic [15:0]            cnt;
  logic                   arm;
  logic                   m_fa = 1'b0;
  logic                   m_fb = 1'b0;
  logic [31:0]            e_rd = 32'h00000000;
  logic                   e_req = 1'b0;
  logic                   e_aft = 1'b0;
  break_pkg::take_t       e_take = break_pkg::TAKE_NONE;

  core_pipe_model core (.cyc(cyc), .acc(acc));
  user_break_match_unit uut (.sys_clk(sys_clk), .srst(srst), .cyc(cyc), .acc(acc),
    .rd_data(rd_data), .break_req(break_req), .break_after(break_after), .take(take),
    .flag_a(flag_a), .flag_b(flag_b));

  // Clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Hang guard
  always @(posedge sys_clk)
  begin
    n_cycles <= n_cycles + 1;
    if (n_cycles == 5000)
    begin
      n_errors = n_errors + 1;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("counts: %0d checks, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  // ==========================================================
  // Reference match of one channel
  function automatic logic mhit(input int ch, input break_pkg::bus_cycle_t c);
    logic [31:0] mk;
    logic [7:0]  s;
    logic [31:0] ex;
    s  = cfg[ch*4+2][7:0];
    mk = cfg[ch*4+1];
    ex = (c.size == 2'h3) ? 32'hFFFFFFFF : (c.size == 2'h2) ? 32'h0000FFFF : 32'h000000FF;
    if (!c.valid || s[7:6] != (c.dma ? 2'h2 : 2'h1)) return 1'b0;
    if (s[5:4] != 2'h0 && s[5:4] != (c.fetch ? 2'h1 : 2'h2)) return 1'b0;
    if (s[3:2] != 2'h0 && s[3:2] != (c.write ? 2'h2 : 2'h1)) return 1'b0;
    if (s[1:0] != 2'h0 && s[1:0] != c.size) return 1'b0;
    if (!c.fetch) mk = mk | ((c.size == 2'h3) ? 32'h3 : {31'h0, c.size == 2'h2});
    if (((cfg[ch*4] ^ c.addr) & ~mk) != 32'h0) return 1'b0;
    if (!cfg[10][21-ch] && cfg[ch*4+3][7:0] != c.asid) return 1'b0;
    if (ch == 1 && cfg[10][7] && !c.fetch && ((cfg[8] ^ c.data) & ~cfg[9] & ex) != 0)
      return 1'b0;
    return 1'b1;
  endfunction : mhit

  // One cycle: check last results, drive, then advance the model
  task automatic step(input break_pkg::bus_cycle_t c, input break_pkg::cfg_access_t a);
    logic ah, bh, bb, ab, aft, bef, wr;
    @(negedge sys_clk);
    check(rd_data, e_rd);
    check(break_req, e_req);
    check(break_after, e_aft);
    check(take, e_take);
    check({flag_a, flag_b}, {m_fa, m_fb});
    core.drive(c, a);
    ah = mhit(0, c);
    bh = mhit(1, c);
    bb = bh;
    if (cfg[10][3])
      bb = bh && (arm || (ah && cfg[2][5:4] == 2'h1 && !cfg[10][10]));
    ab = ah && !cfg[10][3];
    if (bb && cfg[10][0])
    begin
      bb  = (cnt <= 1);
      cnt = bb ? cfg[11][15:0] : cnt - 16'h1;
    end
    arm    = bb ? 1'b0 : (arm || (ah && !bh));
    aft    = (ab && cfg[10][10]) || (bb && cfg[10][6]);
    bef    = (ab && !cfg[10][10]) || (bb && !cfg[10][6]);
    e_req  = (ab || bb) && !c.fetch_exc && (!c.operand_exc || bef);
    e_aft  = e_req && aft;
    e_take = c.fetch_exc ? break_pkg::TAKE_FETCH : (c.operand_exc && !e_req) ?
             break_pkg::TAKE_OPERAND : e_req ? break_pkg::TAKE_BREAK : break_pkg::TAKE_NONE;
    wr     = a.req && a.write && !a.from_dma;
    m_fa   = ((wr && a.index == 4'hA) ? a.wdata[15] : m_fa) || ah;
    m_fb   = ((wr && a.index == 4'hA) ? a.wdata[14] : m_fb) || bb;
    e_rd   = (a.req && !a.write && !a.from_dma && a.index <= 4'hB) ? cfg[a.index] : '0;
    if (wr && a.index <= 4'hB)
      cfg[a.index] = a.wdata & ((a.index == 4'hB) ? 32'hFFFF :
                     (a.index inside {4'h2, 4'h3, 4'h6, 4'h7}) ? 32'hFF : 32'hFFFFFFFF);
    if (wr && a.index == 4'hB)
      cnt = a.wdata[15:0];
  endtask : step

  task automatic put(input logic [3:0] i, input logic [31:0] v);
    step('0, {3'b110, i, v});
  endtask : put

  task automatic get(input logic [3:0] i, input logic dma);
    step('0, {2'b10, dma, i, 32'h0});
  endtask : get

  task automatic bc(input logic dma, fetch, write, input logic [1:0] size,
                    input logic [31:0] addr, data, input logic [7:0] asid,
                    input logic [1:0] exc);
    step({1'b1, dma, fetch, write, size, addr, data, asid, exc}, '0);
  endtask : bc

  task automatic ftc(input logic [31:0] addr, input logic [7:0] asid);
    bc(1'b0, 1'b1, 1'b0, 2'h2, addr, 32'h0, asid, 2'b00);
  endtask : ftc

  // Check the last cycle, reset, then load every setting and read the last one back
  task automatic setup(input logic [31:0] aa, am, ba, bm, bd, bdm, ctl,
                       input logic [7:0] sa, sb, asa, asb, input logic [15:0] n);
    step('0, '0);
    srst = 1'b1;
    repeat (4) @(negedge sys_clk);
    srst = 1'b0;
    core.drive('0, '0);
    foreach (cfg[i]) cfg[i] = '0;
    {cnt, arm, m_fa, m_fb, e_rd, e_req, e_aft} = '0;
    e_take = break_pkg::TAKE_NONE;
    put(4'h0, aa);
    put(4'h1, am);
    put(4'h2, {24'h0, sa});
    put(4'h3, {24'h0, asa});
    put(4'h4, ba);
    put(4'h5, bm);
    put(4'h6, {24'h0, sb});
    put(4'h7, {24'h0, asb});
    put(4'h8, bd);
    put(4'h9, bdm);
    put(4'hA, ctl);
    put(4'hB, {16'h0, n});
    get(4'hB, 1'b0);
  endtask : setup

  // ==========================================================
  // Scenarios
  initial
  begin
    logic f, w;
    logic [31:0] ctl;
    void'($urandom(17));
    setup(32'h404, 0, 32'h8010, 32'h6, 0, 0, 32'h00300400, 8'h54, 8'h54, 0, 0, 0);
    for (int k = 0; k < 6; k++) ftc(32'h8010 + 2 * k, 8'h0);
    ftc(32'h404, 8'h0);
    ftc(32'h406, 8'h0);
    $display("test independent done");
    setup(32'h37226, 0, 32'h3722E, 0, 0, 0, 32'h8, 8'h56, 8'h56, 8'h80, 8'h70, 0);
    ftc(32'h3722E, 8'h70);
    ftc(32'h37226, 8'h70);
    ftc(32'h37226, 8'h80);
    ftc(32'h3722E, 8'h80);
    ftc(32'h3722E, 8'h70);
    ftc(32'h3722E, 8'h70);
    setup(32'h2000, 0, 32'h2000, 0, 0, 0, 32'h00300008, 8'h64, 8'h64, 0, 0, 0);
    bc(1'b0, 1'b0, 1'b0, 2'h2, 32'h2000, 0, 0, 2'b00);
    bc(1'b0, 1'b0, 1'b0, 2'h2, 32'h2000, 0, 0, 2'b00);
    setup(32'h2000, 0, 32'h2000, 0, 0, 0, 32'h00300008, 8'h54, 8'h54, 0, 0, 0);
    ftc(32'h2000, 8'h0);
    $display("test sequence done");
    setup(32'h27128, 0, 32'h31415, 0, 0, 0, 32'h00300000, 8'h5A, 8'h54, 0, 0, 0);
    ftc(32'h27128, 8'h0);
    ftc(32'h31414, 8'h0);
    setup(0, 0, 32'h1000, 0, 0, 0, 32'h00300001, 8'h0, 8'h54, 0, 0, 16'h5);
    repeat (11) ftc(32'h1000, 8'h0);
    $display("test reject and count done");
    setup(32'h123456, 0, 32'hABCDE, 32'hFF, 32'hA512, 0, 32'h80, 8'h64, 8'h6A, 8'h80, 8'h70, 0);
    for (int z = 1; z < 4; z++) bc(1'b0, 1'b0, 1'b0, 2'(z), 32'h123454, 0, 8'h80, 0);
    bc(1'b0, 1'b0, 1'b0, 2'h1, 32'h123456, 0, 8'h80, 0);
    bc(1'b0, 1'b0, 1'b1, 2'h2, 32'hABC10, 32'hA512, 8'h70, 0);
    bc(1'b0, 1'b0, 1'b1, 2'h2, 32'hABC10, 32'hA513, 8'h70, 0);
    bc(1'b0, 1'b0, 1'b1, 2'h3, 32'hABD10, 32'hA512, 8'h70, 0);
    // Byte value replicated into both low bytes of data and mask
    setup(32'h314156, 0, 32'h55555, 0, 32'h7878, 32'h0F0F, 32'h80, 8'h94, 8'hA9, 8'h80, 8'h70, 0);
    bc(1'b1, 1'b0, 1'b0, 2'h1, 32'h314156, 0, 8'h80, 0);
    bc(1'b1, 1'b0, 1'b1, 2'h1, 32'h55555, 32'h7C, 8'h70, 0);
    bc(1'b1, 1'b0, 1'b1, 2'h1, 32'h55555, 32'h68, 8'h70, 0);
    bc(1'b0, 1'b0, 1'b1, 2'h1, 32'h55555, 32'h7C, 8'h70, 0);
    $display("test data done");
    setup(32'h404, 0, 0, 0, 0, 0, 32'h00300000, 8'h54, 8'h0, 0, 0, 0);
    step('0, {3'b111, 4'h0, 32'h600});
    get(4'h0, 1'b0);
    get(4'h0, 1'b1);
    get(4'hE, 1'b0);
    step({1'b1, 5'b01010, 32'h404, 32'h0, 8'h0, 2'b00}, {3'b110, 4'h0, 32'h600});
    ftc(32'h404, 8'h0);
    for (int e = 0; e < 8; e++)
    begin
      if (e == 4) put(4'hA, 32'h00300400);
      bc(1'b0, 1'b1, 1'b0, 2'h2, 32'h600, 0, 0, 2'(e));
    end
    $display("test access and priority done");
    repeat (3)
    begin
      ctl = 32'h00300000 | ($urandom & 32'h481);
      ctl[6] = ctl[10];
      setup(32'h9000, $urandom & 32'hFF, 32'h9000, $urandom & 32'hFF, $urandom,
            $urandom & 32'hF0F0, ctl, {4'h5, 2'($urandom_range(2)), 2'h0},
            {1'b0, 1'($urandom), 2'($urandom_range(2, 1)), 2'($urandom_range(2)), 2'h0},
            8'h80, 8'h70, 16'($urandom_range(3)));
      repeat (100)
      begin
        f = 1'($urandom);
        w = !f && 1'($urandom);
        bc(!f && 1'($urandom), f, w, f ? 2'h2 : 2'($urandom_range(3, 1)),
           (32'h9000 ^ ($urandom & 32'h1FF)) & (f ? ~32'h1 : ~32'h0), $urandom,
           1'($urandom) ? 8'h80 : 8'h70, 2'b00);
      end
    end
    $display("test random done");
    step('0, '0);
    print_verdict();
  end
endmodule : user_break_match_unit_tb
